// >>> psc_defines.svh
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// register offsets
`define PSC_ADDR_OVP_DEB      8'h1e
`define PSC_ADDR_PD_PROT      8'h1f
`define PSC_ADDR_NEG_DEB_HYS  8'h20
`define PSC_ADDR_POS_DUTY     8'h21
`define PSC_ADDR_NEG_DUTY     8'h22
`define PSC_ADDR_POS_TRIM     8'h23
`define PSC_ADDR_NEG_TRIM     8'h24
`define PSC_ADDR_HIGH_PUMP    8'h25
`define PSC_ADDR_LOW_PUMP     8'h26
`define PSC_REG_COUNT         9

// reset values
`define PSC_RST_OVP_DEB       8'h03
`define PSC_RST_PD_PROT       8'h33
`define PSC_RST_NEG_DEB_HYS   8'h00
`define PSC_RST_POS_DUTY      8'h00
`define PSC_RST_NEG_DUTY      8'h00
`define PSC_RST_POS_TRIM      8'h03
`define PSC_RST_NEG_TRIM      8'h03
`define PSC_RST_HIGH_PUMP     8'h74
`define PSC_RST_LOW_PUMP      8'hc4

// writable bit masks, reserved bits clear
`define PSC_MSK_OVP_DEB       8'h07
`define PSC_MSK_PD_PROT       8'h3f
`define PSC_MSK_NEG_DEB_HYS   8'h33
`define PSC_MSK_POS_DUTY      8'hff
`define PSC_MSK_NEG_DUTY      8'hff
`define PSC_MSK_POS_TRIM      8'h77
`define PSC_MSK_NEG_TRIM      8'h77
`define PSC_MSK_HIGH_PUMP     8'hf7
`define PSC_MSK_LOW_PUMP      8'hc7

// field positions
`define PSC_F_POS_PD_EN       5
`define PSC_F_NEG_PD_EN       4
`define PSC_F_OCP_EN          3
`define PSC_F_SEL3_LSB        0
`define PSC_F_NOISE_LSB       4
`define PSC_F_HYS_LSB         0
`define PSC_F_ADD_LSB         4
`define PSC_F_SUB_LSB         0
`define PSC_F_TRIM_LSB        4
`define PSC_F_OFS_LSB         0
`define PSC_F_HRATIO_LSB      6
`define PSC_F_HMODE_LSB       4
`define PSC_F_LRATIO          7
`define PSC_F_LMODE           6

// timing
`define PSC_CLK_PERIOD_NS     4
`define PSC_DEB_UNIT_NS       1000000
`define PSC_NOISE_BASE_COUNT  3
`define PSC_HYS_STEP_MV       10
`define PSC_PUMP_KHZ_BASE     100
`define PSC_PUMP_KHZ_STEP     50

`endif

// >>> psc_pkg.sv
package psc_pkg;
  typedef logic [7:0] psc_byte_t;
  typedef logic signed [3:0] psc_trim_t;
  // pump clock source taken from the select code msb
  typedef enum logic [1:0] {
    PSC_CLK_LINE  = 2'b01,
    PSC_CLK_FIXED = 2'b10
  } psc_pump_src_t;
endpackage

// >>> power_supply_config_regs.sv
`timescale 1ns/10ps
`include "psc_defines.svh"
module power_supply_config_regs
  import psc_pkg::*;
#(
  parameter int DEB_UNIT_CYCLES = `PSC_DEB_UNIT_NS / `PSC_CLK_PERIOD_NS
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  input  wire logic       posOverVoltRaw,
  input  wire logic       negOverVoltRaw,
  input  wire logic       posReadyRaw,
  input  wire logic       negReadyRaw,
  output logic            posOverVoltQual,
  output logic            negOverVoltQual,
  output logic            posReadyQual,
  output logic            negReadyQual,
  input  wire logic       powerOffSeq,
  output logic            posPowerDown,
  output logic            negPowerDown,
  input  wire logic       overCurrentDet,
  output logic            convShutdown,
  input  wire logic       negNoiseTick,
  input  wire logic       negNoiseRaw,
  output logic            negNoiseFilt,
  output logic      [5:0] negHystMv,
  output logic      [3:0] posDutyAdd,
  output logic      [3:0] posDutySub,
  output logic      [3:0] negDutyAdd,
  output logic      [3:0] negDutySub,
  output logic      [3:0] posTrimSteps,
  output logic      [3:0] negTrimSteps,
  output logic      [2:0] posOffsetSel,
  output logic      [2:0] negOffsetSel,
  output logic      [2:0] highPumpRatio,
  output logic      [1:0] highPumpCaps,
  output logic      [1:0] highPumpClkSrc,
  output logic      [1:0] highPumpLineIdx,
  output logic      [7:0] highPumpKhz,
  output logic      [2:0] lowPumpRatio,
  output logic            lowPumpCapMode,
  output logic      [1:0] lowPumpClkSrc,
  output logic      [1:0] lowPumpLineIdx,
  output logic      [7:0] lowPumpKhz
);

  localparam int NREG = `PSC_REG_COUNT;
  localparam psc_byte_t BASE = `PSC_ADDR_OVP_DEB;
  localparam psc_byte_t RST [NREG] = '{`PSC_RST_OVP_DEB, `PSC_RST_PD_PROT,
    `PSC_RST_NEG_DEB_HYS, `PSC_RST_POS_DUTY, `PSC_RST_NEG_DUTY,
    `PSC_RST_POS_TRIM, `PSC_RST_NEG_TRIM, `PSC_RST_HIGH_PUMP,
    `PSC_RST_LOW_PUMP};
  localparam psc_byte_t MSK [NREG] = '{`PSC_MSK_OVP_DEB, `PSC_MSK_PD_PROT,
    `PSC_MSK_NEG_DEB_HYS, `PSC_MSK_POS_DUTY, `PSC_MSK_NEG_DUTY,
    `PSC_MSK_POS_TRIM, `PSC_MSK_NEG_TRIM, `PSC_MSK_HIGH_PUMP,
    `PSC_MSK_LOW_PUMP};

  psc_byte_t   reg_q [NREG];
  logic  [7:0] idx;
  logic        hit;

  assign idx = regAddr - BASE;
  assign hit = (regAddr >= BASE) && (idx < 8'(NREG));

  // register file
  genvar r;
  generate
    for (r = 0; r < NREG; r++)
    begin : g_reg
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          reg_q[r] <= RST[r];
        else if (regWrEn && hit && idx == 8'(r))
          reg_q[r] <= regWrData & MSK[r];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= 8'h00;
    else if (regRdEn)
      regRdData <= hit ? reg_q[idx[3:0]] : 8'h00;
  end

  psc_byte_t ovpReg, pdReg, dhReg, pdutyReg, ndutyReg;
  psc_byte_t ptrimReg, ntrimReg, hpReg, lpReg;
  assign ovpReg   = reg_q[0];
  assign pdReg    = reg_q[1];
  assign dhReg    = reg_q[2];
  assign pdutyReg = reg_q[3];
  assign ndutyReg = reg_q[4];
  assign ptrimReg = reg_q[5];
  assign ntrimReg = reg_q[6];
  assign hpReg    = reg_q[7];
  assign lpReg    = reg_q[8];

  // debounce time base
  logic [19:0] unitCnt_q;
  logic        unitTick;
  assign unitTick = (unitCnt_q == 20'(DEB_UNIT_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      unitCnt_q <= 20'h00000;
    else if (unitTick)
      unitCnt_q <= 20'h00000;
    else
      unitCnt_q <= unitCnt_q + 20'h00001;
  end

  // channels: 0 pos ovp, 1 neg ovp, 2 pos ready, 3 neg ready
  logic [3:0] condRaw;
  logic [3:0] qual_q;
  logic [7:0] debCnt_q [4];
  logic [7:0] debTarget [4];
  assign condRaw = {negReadyRaw, posReadyRaw, negOverVoltRaw, posOverVoltRaw};
  assign debTarget[0] = 8'h01 << ovpReg[`PSC_F_SEL3_LSB +: 3];
  assign debTarget[1] = debTarget[0];
  assign debTarget[2] = 8'h01 << pdReg[`PSC_F_SEL3_LSB +: 3];
  assign debTarget[3] = debTarget[2];

  genvar c;
  generate
    for (c = 0; c < 4; c++)
    begin : g_deb
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          debCnt_q[c] <= 8'h00;
        else if (!condRaw[c])
          debCnt_q[c] <= 8'h00;
        else if (unitTick && debCnt_q[c] < debTarget[c])
          debCnt_q[c] <= debCnt_q[c] + 8'h01;
      end
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          qual_q[c] <= 1'b0;
        else
          qual_q[c] <= condRaw[c] && (debCnt_q[c] >= debTarget[c]);
      end
    end
  endgenerate

  assign posOverVoltQual = qual_q[0];
  assign negOverVoltQual = qual_q[1];
  assign posReadyQual    = qual_q[2];
  assign negReadyQual    = qual_q[3];

  // power-off sequence and protection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      posPowerDown <= 1'b0;
      negPowerDown <= 1'b0;
      convShutdown <= 1'b0;
    end
    else
    begin
      posPowerDown <= powerOffSeq && pdReg[`PSC_F_POS_PD_EN];
      negPowerDown <= powerOffSeq && pdReg[`PSC_F_NEG_PD_EN];
      convShutdown <= overCurrentDet && pdReg[`PSC_F_OCP_EN];
    end
  end

  // negative-supply noise filter
  logic [2:0] noiseCnt_q;
  logic [2:0] noiseNeed;
  assign noiseNeed = 3'(`PSC_NOISE_BASE_COUNT) +
                     {1'b0, dhReg[`PSC_F_NOISE_LSB +: 2]};
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      noiseCnt_q   <= 3'h0;
      negNoiseFilt <= 1'b0;
    end
    else if (negNoiseTick)
    begin
      if (negNoiseRaw == negNoiseFilt)
        noiseCnt_q <= 3'h0;
      else if (noiseCnt_q + 3'h1 >= noiseNeed)
      begin
        noiseCnt_q   <= 3'h0;
        negNoiseFilt <= negNoiseRaw;
      end
      else
        noiseCnt_q <= noiseCnt_q + 3'h1;
    end
  end

  function automatic logic [3:0] trimDecode(input logic [2:0] code);
    unique case (code)
      3'h6:    trimDecode = 4'hf;
      3'h7:    trimDecode = 4'he;
      default: trimDecode = {1'b0, code};
    endcase
  endfunction

  function automatic logic [7:0] khzDecode(input logic [2:0] code);
    khzDecode = code[2] ? 8'(`PSC_PUMP_KHZ_BASE) +
                8'(`PSC_PUMP_KHZ_STEP) * {6'h00, code[1:0]} : 8'h00;
  endfunction

  // decoded settings for the analog side
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      negHystMv       <= 6'h00;
      posDutyAdd      <= 4'h0;
      posDutySub      <= 4'h0;
      negDutyAdd      <= 4'h0;
      negDutySub      <= 4'h0;
      posTrimSteps    <= 4'h0;
      negTrimSteps    <= 4'h0;
      posOffsetSel    <= 3'h0;
      negOffsetSel    <= 3'h0;
      highPumpRatio   <= 3'h0;
      highPumpCaps    <= 2'h0;
      highPumpClkSrc  <= 2'h0;
      highPumpLineIdx <= 2'h0;
      highPumpKhz     <= 8'h00;
      lowPumpRatio    <= 3'h0;
      lowPumpCapMode  <= 1'b0;
      lowPumpClkSrc   <= 2'h0;
      lowPumpLineIdx  <= 2'h0;
      lowPumpKhz      <= 8'h00;
    end
    else
    begin
      negHystMv <= 6'(`PSC_HYS_STEP_MV) *
                   ({4'h0, dhReg[`PSC_F_HYS_LSB +: 2]} + 6'h01);
      posDutyAdd <= pdutyReg[`PSC_F_ADD_LSB +: 4];
      posDutySub <= pdutyReg[`PSC_F_SUB_LSB +: 4];
      negDutyAdd <= ndutyReg[`PSC_F_ADD_LSB +: 4];
      negDutySub <= ndutyReg[`PSC_F_SUB_LSB +: 4];
      posTrimSteps <= trimDecode(ptrimReg[`PSC_F_TRIM_LSB +: 3]);
      negTrimSteps <= trimDecode(ntrimReg[`PSC_F_TRIM_LSB +: 3]);
      posOffsetSel <= ptrimReg[`PSC_F_OFS_LSB +: 3];
      negOffsetSel <= ntrimReg[`PSC_F_OFS_LSB +: 3];
      unique case (hpReg[`PSC_F_HRATIO_LSB +: 2])
        2'h0:    highPumpRatio <= 3'h2;
        2'h1:    highPumpRatio <= 3'h3;
        default: highPumpRatio <= 3'h4;
      endcase
      unique case (hpReg[`PSC_F_HMODE_LSB +: 2])
        2'h0:    highPumpCaps <= 2'h1;
        2'h3:    highPumpCaps <= 2'h3;
        default: highPumpCaps <= 2'h2;
      endcase
      highPumpClkSrc  <= hpReg[2] ? PSC_CLK_FIXED : PSC_CLK_LINE;
      highPumpLineIdx <= hpReg[1:0];
      highPumpKhz     <= khzDecode(hpReg[2:0]);
      lowPumpRatio   <= lpReg[`PSC_F_LRATIO] ? 3'h2 : 3'h2;
      lowPumpCapMode <= lpReg[`PSC_F_LMODE];
      lowPumpClkSrc  <= lpReg[2] ? PSC_CLK_FIXED : PSC_CLK_LINE;
      lowPumpLineIdx <= lpReg[1:0];
      lowPumpKhz     <= khzDecode(lpReg[2:0]);
    end
  end

  ovp_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(posOverVoltQual) |-> $past(posOverVoltRaw, 1) &&
      $past(debCnt_q[0], 1) >= $past(debTarget[0], 1))
    else $error("over-voltage qualified too early");
  deb_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
    !posReadyRaw |=> !posReadyQual && debCnt_q[2] == 8'h00)
    else $error("debounce did not restart");
  ready_min_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(negReadyQual) |-> $past(debCnt_q[3], 1) != 8'h00)
    else $error("ready qualified without time base");
  pos_pd_a: assert property (@(posedge clk) disable iff (!rst_b)
    powerOffSeq && !pdReg[`PSC_F_POS_PD_EN] ##1
      !pdReg[`PSC_F_POS_PD_EN] |-> !posPowerDown)
    else $error("positive power-down ran while disabled");
  neg_pd_a: assert property (@(posedge clk) disable iff (!rst_b)
    powerOffSeq && pdReg[`PSC_F_NEG_PD_EN] |=> negPowerDown)
    else $error("negative power-down missing");
  ocp_shut_a: assert property (@(posedge clk) disable iff (!rst_b)
    convShutdown |-> $past(overCurrentDet) && $past(pdReg[`PSC_F_OCP_EN]))
    else $error("shutdown without enabled over-current");
  // filter changes only after enough samples
  noise_filt_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(negNoiseFilt) |-> $past(negNoiseTick) &&
      $past(noiseCnt_q) + 3'h1 >= $past(noiseNeed))
    else $error("noise accepted too early");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    regRdEn && regAddr == `PSC_ADDR_PD_PROT |=> regRdData[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
  ratio_dec_a: assert property (@(posedge clk) disable iff (!rst_b)
    hpReg[`PSC_F_HRATIO_LSB +: 2] == 2'h1 ##1
      hpReg[`PSC_F_HRATIO_LSB +: 2] == 2'h1 |-> highPumpRatio == 3'h3)
    else $error("high pump ratio wrong");

endmodule // power_supply_config_regs

// >>> tb_power_supply_config_regs.sv
`timescale 1ns/10ps
`include "psc_defines.svh"
module tb_power_supply_config_regs
  import psc_pkg::*;
();
  localparam int U = 4;
  logic       clk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0;
  logic [7:0] regAddr = 0, regWrData = 0;
  logic       posOverVoltRaw = 0, negOverVoltRaw = 0;
  logic       posReadyRaw = 0, negReadyRaw = 0;
  logic       powerOffSeq = 0, overCurrentDet = 0;
  logic       negNoiseTick = 0, negNoiseRaw = 0;
  logic [7:0] regRdData, highPumpKhz, lowPumpKhz;
  logic       posOverVoltQual, negOverVoltQual, posReadyQual, negReadyQual;
  logic       posPowerDown, negPowerDown, convShutdown, negNoiseFilt;
  logic       lowPumpCapMode;
  logic [5:0] negHystMv;
  logic [3:0] posDutyAdd, posDutySub, negDutyAdd, negDutySub;
  logic [3:0] posTrimSteps, negTrimSteps;
  logic [2:0] posOffsetSel, negOffsetSel, highPumpRatio, lowPumpRatio;
  logic [1:0] highPumpCaps, highPumpClkSrc, highPumpLineIdx;
  logic [1:0] lowPumpClkSrc, lowPumpLineIdx;
  psc_byte_t  model [9];
  psc_byte_t  msk [9];
  int         miscompares = 0, compares = 0, cyc = 0;
  logic [31:0] seed = 32'hc31bab37;

  power_supply_config_regs #(.DEB_UNIT_CYCLES(U)) i_dut (
    .clk, .rst_b, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .posOverVoltRaw, .negOverVoltRaw, .posReadyRaw, .negReadyRaw,
    .posOverVoltQual, .negOverVoltQual, .posReadyQual, .negReadyQual,
    .powerOffSeq, .posPowerDown, .negPowerDown, .overCurrentDet,
    .convShutdown, .negNoiseTick, .negNoiseRaw, .negNoiseFilt, .negHystMv,
    .posDutyAdd, .posDutySub, .negDutyAdd, .negDutySub, .posTrimSteps,
    .negTrimSteps, .posOffsetSel, .negOffsetSel, .highPumpRatio,
    .highPumpCaps, .highPumpClkSrc, .highPumpLineIdx, .highPumpKhz,
    .lowPumpRatio, .lowPumpCapMode, .lowPumpClkSrc, .lowPumpLineIdx,
    .lowPumpKhz
  );

  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrEn = 1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrEn = 0;
    if (a >= 8'h1e && a <= 8'h26)
      model[a - 8'h1e] = d & msk[a - 8'h1e];
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= 8'h1e && a <= 8'h26) ? model[a - 8'h1e] : 8'h00;
    @(negedge clk);
    regRdEn = 1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 0;
    regAddr = 8'(rnd());
    @(negedge clk);
    chk("read data", regRdData, e);
  endtask

  function automatic logic [3:0] trimOf(input logic [2:0] c);
    return c == 6 ? 4'hf : c == 7 ? 4'he : {1'b0, c};
  endfunction

  task automatic chkClk(input string nm, input logic [1:0] src,
                        input logic [1:0] idx, input logic [7:0] khz,
                        input logic [2:0] c);
    chk(nm, {src, idx}, {c[2] ? 2'b10 : 2'b01, c[1:0]});
    chk(nm, khz, c[2] ? 8'(100 + 50 * c[1:0]) : 8'h00);
  endtask

  task automatic chkOut();
    psc_byte_t h;
    h = model[7];
    repeat (2) @(negedge clk);
    chk("hysteresis", 8'(negHystMv), 8'(10 + 10 * model[2][1:0]));
    chk("pos duty", {posDutyAdd, posDutySub}, model[3]);
    chk("neg duty", {negDutyAdd, negDutySub}, model[4]);
    chk("pos trim", {posTrimSteps, 1'b0, posOffsetSel},
        {trimOf(model[5][6:4]), model[5][3:0]});
    chk("neg trim", {negTrimSteps, 1'b0, negOffsetSel},
        {trimOf(model[6][6:4]), model[6][3:0]});
    chk("high ratio", 8'(highPumpRatio),
        h[7:6] == 0 ? 8'd2 : h[7:6] == 1 ? 8'd3 : 8'd4);
    chk("high caps", 8'(highPumpCaps),
        h[5:4] == 0 ? 8'd1 : h[5:4] == 3 ? 8'd3 : 8'd2);
    chkClk("high clock", highPumpClkSrc, highPumpLineIdx, highPumpKhz,
           h[2:0]);
    chkClk("low clock", lowPumpClkSrc, lowPumpLineIdx, lowPumpKhz,
           model[8][2:0]);
    chk("low ratio", {lowPumpRatio, lowPumpCapMode},
        {3'd2, model[8][6]});
    chk("power down", {posPowerDown, negPowerDown, convShutdown},
        {powerOffSeq & model[1][5], powerOffSeq & model[1][4],
         overCurrentDet & model[1][3]});
  endtask

  task automatic setRaw(input logic v);
    posOverVoltRaw = v;
    negOverVoltRaw = v;
    posReadyRaw = v;
    negReadyRaw = v;
  endtask

  task automatic deb(input logic [2:0] sel, input bit glitch);
    int n;
    n = 0;
    wr(8'h1e, {5'h1f, sel});
    wr(8'h1f, {5'h06, sel});
    @(negedge clk);
    setRaw(1);
    if (glitch)
    begin
      repeat (10) @(negedge clk);
      setRaw(0);
      @(negedge clk);
      setRaw(1);
    end
    while (posOverVoltQual !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    chk("debounce early", 8'(n >= ((1 << sel) - 1) * U), 8'd1);
    chk("debounce late", 8'(n <= (1 << sel) * U + 4), 8'd1);
    chk("qualified", {posOverVoltQual, negOverVoltQual, posReadyQual,
        negReadyQual}, 8'h0f);
    setRaw(0);
    repeat (2) @(negedge clk);
    chk("dropped", {posOverVoltQual, negOverVoltQual, posReadyQual,
        negReadyQual}, 8'h00);
  endtask

  task automatic tk(input logic v, input int k);
    repeat (k)
    begin
      @(negedge clk);
      negNoiseTick = 1;
      negNoiseRaw = v;
      @(negedge clk);
      negNoiseTick = 0;
      negNoiseRaw = ~v;
      @(negedge clk);
    end
  endtask

  initial
  begin
    logic [31:0] x;
    msk = '{`PSC_MSK_OVP_DEB, `PSC_MSK_PD_PROT, `PSC_MSK_NEG_DEB_HYS,
            `PSC_MSK_POS_DUTY, `PSC_MSK_NEG_DUTY, `PSC_MSK_POS_TRIM,
            `PSC_MSK_NEG_TRIM, `PSC_MSK_HIGH_PUMP, `PSC_MSK_LOW_PUMP};
    model = '{8'h03, 8'h33, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h74,
              8'hc4};
    repeat (2) @(negedge clk);
    rst_b = 1;
    for (int i = 0; i < 11; i++)
      rd(8'(8'h1d + i));
    chkOut();
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h20, {4'hc | 4'(c & 3), 4'hc | 4'(c & 3)});
      wr(8'h23, {1'b1, 3'(c), 1'b1, 3'(c)});
      wr(8'h24, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
      wr(8'h25, {2'(c), 2'(c), 1'b1, 3'(c)});
      wr(8'h26, {2'(c), 3'h7, 3'(7 - c)});
      rd(8'h25);
      chkOut();
    end
    for (int i = 0; i < 60; i++)
    begin
      x = rnd();
      powerOffSeq = x[8];
      overCurrentDet = x[9];
      wr(8'(8'h1d + x[7:0] % 11), x[31:24]);
      rd(8'(8'h1d + x[19:12] % 11));
      chkOut();
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h20, {2'b0, 2'(s), 4'h0});
      tk(1, s + 2);
      tk(0, 1);
      tk(1, s + 2);
      chk("noise held", 8'(negNoiseFilt), 8'h00);
      tk(1, 1);
      chk("noise taken", 8'(negNoiseFilt), 8'h01);
      tk(0, s + 3);
      chk("noise back", 8'(negNoiseFilt), 8'h00);
    end
    // every debounce select code, then a restart after a drop
    for (int d = 0; d < 8; d++)
      deb(3'(d), 0);
    deb(3'd2, 1);
    deb(3'd3, 1);
    final_report();
  end
endmodule // tb_power_supply_config_regs
